// *** design/usb_err_pkg.sv ***
// Constants and types for the USB error flag and mask block
`default_nettype none
package usb_err_pkg;
	// Register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int FLAG_W = 8;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_ERR_FLAGS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ERR_ENABLES = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SUMMARY = 8'h0C;
	// Error flag bit positions
	localparam int POS_BIT_STUFF = 7;
	localparam int POS_BUS_ADDR = 6;
	localparam int POS_DMA = 5;
	localparam int POS_TURNAROUND = 4;
	localparam int POS_FIELD_SIZE = 3;
	localparam int POS_DATA_CRC = 2;
	localparam int POS_SHARED = 1;
	localparam int POS_PACKET_ID = 0;
	// Control and summary register bit positions
	localparam int POS_HOST_MODE = 0;
	localparam int POS_SUMMARY_EN = 1;
	localparam int POS_SUMMARY_FLAG = 0;
	localparam int POS_IRQ_REQUEST = 1;
	// Reset values and bus answers
	localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
	localparam logic [FLAG_W-1:0] ENABLES_RESET = 8'h00;
	localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Error events from the packet engine and DMA path
	typedef struct packed {
		logic bit_stuff;
		logic bus_addr;
		logic dma;
		logic turnaround_timeout;
		logic field_size;
		logic data_crc;
		logic token_crc;
		logic end_of_frame;
		logic packet_id;
	} err_event_t;
	// Whole block state
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [DATA_W-1:0] rdata;
		logic [FLAG_W-1:0] flags;
		logic [FLAG_W-1:0] enables;
		logic host_mode;
		logic summary_en;
		logic summary_flag;
		logic irq_request;
	} state_t;
endpackage : usb_err_pkg
`default_nettype wire

// *** design/usb_error_flag_and_mask_logic.sv ***
// USB error flags, error enables and summary interrupt behind AXI4-Lite
// Summary of operation
// - Upper bits read zero, writes ignored
// - Flags set by hardware, cleared writing one
// - Bit seven flags bit stuff rejection
// - Bit six flags invalid bus address
// - Bit five flags DMA overrun or truncation
// - Bit four flags bus turnaround timeout
// - Bit three flags partial-byte data field
// - Bit two flags data CRC failure
// - Device mode bit one: token CRC
// - Host mode bit one: end of frame
// - Bit zero flags packet identifier failure
// - Enables read-write, reset zero, mask flags
// - Summary set only by enabled flags
// - Host select chooses bit one meaning
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`default_nettype none
module usb_error_flag_and_mask_logic
	import usb_err_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// Error events, one-cycle pulses
	input wire err_event_t err_events,
	// Interrupt and mode outputs
	output logic error_summary_irq_flag,
	output logic usb_irq_request,
	output logic host_mode_select
);
	localparam state_t ST_RESET = '{
		flags: FLAGS_RESET,
		enables: ENABLES_RESET,
		rdata: RDATA_ZERO,
		default: '0
	};

	state_t st_q;
	state_t st_d;
	logic wr_fire;
	logic rd_fire;
	logic wr_lane0;
	logic wr_mapped;
	logic rd_mapped;
	logic [FLAG_W-1:0] clr_mask;
	logic [FLAG_W-1:0] ev_bits;

	// Next state of bus slave and register file
	always_comb begin
		st_d = st_q;
		wr_fire = st_q.awready & awvalid & wvalid;
		rd_fire = st_q.arready & arvalid;
		wr_lane0 = wr_fire & wstrb[0];
		wr_mapped = (awaddr == OFS_ERR_FLAGS) || (awaddr == OFS_ERR_ENABLES) ||
			(awaddr == OFS_CONTROL) || (awaddr == OFS_SUMMARY);
		rd_mapped = (araddr == OFS_ERR_FLAGS) || (araddr == OFS_ERR_ENABLES) ||
			(araddr == OFS_CONTROL) || (araddr == OFS_SUMMARY);
		clr_mask = '0;
		ev_bits = '0;
		// Write channel: take address and data together
		st_d.awready = 1'b0;
		st_d.wready = 1'b0;
		if (awvalid && wvalid && !st_q.awready && !st_q.bvalid) begin
			st_d.awready = 1'b1;
			st_d.wready = 1'b1;
		end
		if (st_q.bvalid && bready) begin
			st_d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			st_d.bvalid = 1'b1;
			st_d.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		// Only the low byte holds bits; upper bits are dropped
		if (wr_lane0 && awaddr == OFS_ERR_FLAGS) begin
			clr_mask = wdata[FLAG_W-1:0];
		end
		if (wr_lane0 && awaddr == OFS_ERR_ENABLES) begin
			st_d.enables = wdata[FLAG_W-1:0];
		end
		if (wr_lane0 && awaddr == OFS_CONTROL) begin
			st_d.host_mode = wdata[POS_HOST_MODE];
			st_d.summary_en = wdata[POS_SUMMARY_EN];
		end
		// Map engine events onto flag positions
		ev_bits[POS_BIT_STUFF] = err_events.bit_stuff;
		ev_bits[POS_BUS_ADDR] = err_events.bus_addr;
		ev_bits[POS_DMA] = err_events.dma;
		ev_bits[POS_TURNAROUND] = err_events.turnaround_timeout;
		ev_bits[POS_FIELD_SIZE] = err_events.field_size;
		ev_bits[POS_DATA_CRC] = err_events.data_crc;
		// Shared bit one follows the mode in force
		ev_bits[POS_SHARED] = st_q.host_mode ? err_events.end_of_frame :
			err_events.token_crc;
		ev_bits[POS_PACKET_ID] = err_events.packet_id;
		// Set wins over a clear in the same cycle
		st_d.flags = (st_q.flags & ~clr_mask) | ev_bits;
		// Summary follows enabled flags only
		st_d.summary_flag = |(st_d.flags & st_d.enables);
		st_d.irq_request = st_d.summary_flag & st_d.summary_en;
		// Read channel
		st_d.arready = arvalid & ~st_q.arready & ~st_q.rvalid;
		if (st_q.rvalid && rready) begin
			st_d.rvalid = 1'b0;
		end
		if (rd_fire) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
			st_d.rdata = RDATA_ZERO;
			case (araddr)
				OFS_ERR_FLAGS: begin
					st_d.rdata[FLAG_W-1:0] = st_q.flags;
				end
				OFS_ERR_ENABLES: begin
					st_d.rdata[FLAG_W-1:0] = st_q.enables;
				end
				OFS_CONTROL: begin
					st_d.rdata[POS_HOST_MODE] = st_q.host_mode;
					st_d.rdata[POS_SUMMARY_EN] = st_q.summary_en;
				end
				OFS_SUMMARY: begin
					st_d.rdata[POS_SUMMARY_FLAG] = st_q.summary_flag;
					st_d.rdata[POS_IRQ_REQUEST] = st_q.irq_request;
				end
				default: begin
					st_d.rdata = RDATA_ZERO;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from state flops
	assign awready = st_q.awready;
	assign wready = st_q.wready;
	assign bvalid = st_q.bvalid;
	assign bresp = st_q.bresp;
	assign arready = st_q.arready;
	assign rvalid = st_q.rvalid;
	assign rdata = st_q.rdata;
	assign rresp = st_q.rresp;
	assign error_summary_irq_flag = st_q.summary_flag;
	assign usb_irq_request = st_q.irq_request;
	assign host_mode_select = st_q.host_mode;

	// Read data never shows upper bits
	chk_upper_zero: assert property (@(posedge aclk)
		disable iff (!aresetn) st_q.rvalid |-> st_q.rdata[DATA_W-1:FLAG_W] == '0)
		else $error("upper read bits not zero");

	// A flag falls only under a one written to it
	chk_flag_clear_only: assert property (@(posedge aclk)
		disable iff (!aresetn)
		1'b1 |=> (($past(st_q.flags) & ~st_q.flags) & ~$past(clr_mask)) == '0)
		else $error("flag cleared without write of one");

	// Every event taken in the mode in force lands in its flag next cycle
	chk_event_sets: assert property (@(posedge aclk)
		disable iff (!aresetn)
		ev_bits != '0 |=> (st_q.flags & $past(ev_bits)) == $past(ev_bits))
		else $error("error event did not set its flag");

	// Bit stuff event under a clear still lands
	chk_set_over_clear: assert property (@(posedge aclk)
		disable iff (!aresetn)
		err_events.bit_stuff && clr_mask[POS_BIT_STUFF]
		|=> st_q.flags[POS_BIT_STUFF])
		else $error("clear beat a bit stuff event");

	// Host mode ignores token CRC on bit one
	chk_host_bit1: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st_q.host_mode && err_events.token_crc && !err_events.end_of_frame &&
		!st_q.flags[POS_SHARED] |=> !st_q.flags[POS_SHARED])
		else $error("token crc set bit one in host mode");

	// Device mode ignores end of frame on bit one
	chk_device_bit1: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!st_q.host_mode && err_events.end_of_frame && !err_events.token_crc &&
		!st_q.flags[POS_SHARED] |=> !st_q.flags[POS_SHARED])
		else $error("end of frame set bit one in device mode");

	// Enables take the written byte
	chk_enable_write: assert property (@(posedge aclk)
		disable iff (!aresetn)
		wr_lane0 && awaddr == OFS_ERR_ENABLES
		|=> st_q.enables == $past(wdata[FLAG_W-1:0]))
		else $error("enable register missed write");

	// Summary tracks enabled flags only
	chk_summary_mask: assert property (@(posedge aclk)
		disable iff (!aresetn) st_q.summary_flag == (|(st_q.flags & st_q.enables)))
		else $error("summary flag disagrees with masked flags");

	// Request needs summary and its enable
	chk_irq_gate: assert property (@(posedge aclk)
		disable iff (!aresetn) st_q.irq_request |-> st_q.summary_flag && st_q.summary_en)
		else $error("irq request without enabled summary");

	// Mode select follows control write
	chk_mode_write: assert property (@(posedge aclk)
		disable iff (!aresetn)
		wr_lane0 && awaddr == OFS_CONTROL
		|=> st_q.host_mode == $past(wdata[POS_HOST_MODE]))
		else $error("host mode select missed write");

	// Write answered the cycle after its handshake
	chk_write_resp: assert property (@(posedge aclk)
		disable iff (!aresetn) wr_fire |=> st_q.bvalid)
		else $error("write not answered");

	// Address and data ready rise together
	chk_ready_pair: assert property (@(posedge aclk)
		disable iff (!aresetn) st_q.awready == st_q.wready)
		else $error("write address and data ready split");

	// No new write taken while its answer is pending
	chk_write_busy: assert property (@(posedge aclk)
		disable iff (!aresetn) st_q.bvalid |-> !st_q.awready)
		else $error("write taken with response pending");

	// Read answered the cycle after its address
	chk_read_resp: assert property (@(posedge aclk)
		disable iff (!aresetn) rd_fire |=> st_q.rvalid)
		else $error("read not answered");

	// No new read taken while data is pending
	chk_read_busy: assert property (@(posedge aclk)
		disable iff (!aresetn) st_q.rvalid |-> !st_q.arready)
		else $error("read taken with data pending");

	// A flag rises only under its event
	chk_flag_set_only: assert property (@(posedge aclk)
		disable iff (!aresetn)
		1'b1 |=> ((st_q.flags & ~$past(st_q.flags)) & ~$past(ev_bits)) == '0)
		else $error("flag set without an event");

	// Enables keep their value between writes
	chk_enable_hold: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!(wr_lane0 && awaddr == OFS_ERR_ENABLES) |=> $stable(st_q.enables))
		else $error("enable register changed without write");

	// Mode select keeps its value between writes
	chk_mode_hold: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!(wr_lane0 && awaddr == OFS_CONTROL) |=> $stable(st_q.host_mode))
		else $error("host mode select changed without write");

	// Reset leaves flags, enables, mode and request clear
	chk_reset_clear: assert property (@(posedge aclk)
		!aresetn |=> st_q.flags == FLAGS_RESET && st_q.enables == ENABLES_RESET &&
		!st_q.host_mode && !st_q.irq_request)
		else $error("reset left state behind");

	// Host mode end of frame sets bit one
	chk_host_eof: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st_q.host_mode && err_events.end_of_frame |=> st_q.flags[POS_SHARED])
		else $error("end of frame missed in host mode");

	// Device mode token CRC sets bit one
	chk_device_token: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!st_q.host_mode && err_events.token_crc |=> st_q.flags[POS_SHARED])
		else $error("token crc missed in device mode");

	// Flag read returns the stored flags
	chk_read_flags: assert property (@(posedge aclk)
		disable iff (!aresetn)
		rd_fire && araddr == OFS_ERR_FLAGS
		|=> st_q.rdata[FLAG_W-1:0] == $past(st_q.flags))
		else $error("flag read returned wrong byte");

	// Enable read returns the stored enables
	chk_read_enables: assert property (@(posedge aclk)
		disable iff (!aresetn)
		rd_fire && araddr == OFS_ERR_ENABLES
		|=> st_q.rdata[FLAG_W-1:0] == $past(st_q.enables))
		else $error("enable read returned wrong byte");

	// Unmapped write answered with an error
	chk_unmapped_write: assert property (@(posedge aclk)
		disable iff (!aresetn) wr_fire && !wr_mapped |=> st_q.bresp == RESP_SLVERR)
		else $error("unmapped write answered okay");

	// Enabled summary always raises the request
	chk_irq_follows: assert property (@(posedge aclk)
		disable iff (!aresetn) st_q.summary_flag && st_q.summary_en |-> st_q.irq_request)
		else $error("enabled summary gave no request");
endmodule : usb_error_flag_and_mask_logic
`default_nettype wire

// *** sim/usb_err_source.sv ***
// Error event source standing in for the packet engine detectors
`default_nettype none
module usb_err_source
	import usb_err_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Bench command
	input wire logic fire,
	input wire err_event_t pattern,
	// Events toward the block
	output var err_event_t err_events
);
	// One-cycle pulse per command, quiet otherwise
	always_ff @(posedge aclk) begin
		err_events <= fire ? pattern : '0;
	end
endmodule : usb_err_source
`default_nettype wire

// *** sim/usb_error_flag_and_mask_logic_test.sv ***
// Self-checking bench for the USB error flag and mask block
`default_nettype none
module usb_error_flag_and_mask_logic_test import usb_err_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [8:0] ev; logic hm; logic [7:0] ex;} row_t;
	logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, fire = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, sflag, irq, host;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	err_event_t pattern = '0, err_events;
	int fails = 0, total_checks = 0;
	// Event, mode, expected flag byte
	row_t rows [11] = '{'{9'h100, 1'h0, 8'h80}, '{9'h080, 1'h0, 8'h40}, '{9'h040, 1'h0, 8'h20},
		'{9'h020, 1'h0, 8'h10}, '{9'h010, 1'h0, 8'h08}, '{9'h008, 1'h0, 8'h04},
		'{9'h004, 1'h0, 8'h02}, '{9'h002, 1'h1, 8'h02}, '{9'h001, 1'h1, 8'h01},
		'{9'h004, 1'h1, 8'h00}, '{9'h002, 1'h0, 8'h00}};
	usb_error_flag_and_mask_logic i_usb_error_flag_and_mask_logic (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .err_events(err_events), .error_summary_irq_flag(sflag),
		.usb_irq_request(irq), .host_mode_select(host));
	usb_err_source i_usb_err_source (.aclk(aclk), .fire(fire), .pattern(pattern),
		.err_events(err_events));
	// Clock
	always #5 aclk = ~aclk;
	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Write with both channels offered together
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr
	// Read and compare data and response
	task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready === 1'h1) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
		chk(rdata, exp);
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rd
	// One event pulse through the source model
	task pulse(input logic [8:0] ev);
		@(posedge aclk);
		pattern <= ev;
		fire <= 1'h1;
		@(posedge aclk);
		fire <= 1'h0;
		repeat (2) @(posedge aclk);
	endtask : pulse
	// Verdict
	task results;
		if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// Watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		results();
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		foreach (rows[k]) begin
			wr(OFS_CONTROL, {31'h0, rows[k].hm}, RESP_OKAY);
			pulse(rows[k].ev);
			rd(OFS_ERR_FLAGS, {24'h0, rows[k].ex}, RESP_OKAY);
			wr(OFS_ERR_FLAGS, 32'h000000FF, RESP_OKAY);
		end
		// Enables, unmapped place, masking
		rd(OFS_ERR_FLAGS, 32'h0, RESP_OKAY);
		wr(OFS_ERR_ENABLES, 32'hFFFFFFFF, RESP_OKAY);
		rd(OFS_ERR_ENABLES, 32'h000000FF, RESP_OKAY);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(8'h40, 32'h000000FF, RESP_SLVERR);
		wr(OFS_ERR_ENABLES, 32'h00000020, RESP_OKAY);
		// Low lane off: write answered but ignored
		wstrb <= 4'hE;
		wr(OFS_ERR_ENABLES, 32'h000000FF, RESP_OKAY);
		wstrb <= 4'hF;
		rd(OFS_ERR_ENABLES, 32'h00000020, RESP_OKAY);
		wr(OFS_CONTROL, 32'h0, RESP_OKAY);
		pulse(9'h080);
		chk({29'h0, sflag, irq, host}, 32'h0);
		rd(OFS_ERR_FLAGS, 32'h00000040, RESP_OKAY);
		pulse(9'h040);
		chk({29'h0, sflag, irq, host}, 32'h4);
		wr(OFS_CONTROL, 32'h00000003, RESP_OKAY);
		chk({29'h0, sflag, irq, host}, 32'h7);
		rd(OFS_CONTROL, 32'h00000003, RESP_OKAY);
		wr(OFS_SUMMARY, 32'h0, RESP_OKAY);
		rd(OFS_SUMMARY, 32'h00000003, RESP_OKAY);
		wr(OFS_ERR_FLAGS, 32'hFFFFFF00, RESP_OKAY);
		rd(OFS_ERR_FLAGS, 32'h00000060, RESP_OKAY);
		wr(OFS_ERR_FLAGS, 32'h00000020, RESP_OKAY);
		chk({29'h0, sflag, irq, host}, 32'h1);
		// Event and clear of one bit in the same cycle: set wins
		fork
			wr(OFS_ERR_FLAGS, 32'h000000C0, RESP_OKAY);
			pulse(9'h100);
		join
		rd(OFS_ERR_FLAGS, 32'h00000080, RESP_OKAY);
		// Reset in mid-run clears everything
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rd(OFS_ERR_FLAGS, 32'h0, RESP_OKAY);
		rd(OFS_ERR_ENABLES, 32'h0, RESP_OKAY);
		rd(OFS_CONTROL, 32'h0, RESP_OKAY);
		chk({29'h0, sflag, irq, host}, 32'h0);
		results();
	end
endmodule : usb_error_flag_and_mask_logic_test
`default_nettype wire
